/* design/rcx_pkg.sv */
// Constants shared by the coexistence priority block: register map, field layout, reset values, timing.
// Assumes a 50 MHz master clock and byte addresses on the register port.
package rcx_pkg;

  // Timing
  localparam longint CLK_HZ      = 64'd50_000_000;
  localparam longint US_NS       = 64'd1_000;
  localparam longint CYC_PER_US  = (US_NS * CLK_HZ + 64'd999_999_999) / 64'd1_000_000_000;
  localparam logic [5:0] US_LAST = 6'(CYC_PER_US - 64'd1);

  // Register byte addresses
  localparam logic [31:0] ADDR_COEX_CTRL    = 32'h4000_0100;
  localparam logic [31:0] ADDR_PRIO_TIMING  = 32'h4000_0104;
  localparam logic [31:0] ADDR_PRIO_TABLE_A = 32'h4000_0108;
  localparam logic [31:0] ADDR_PRIO_TABLE_B = 32'h4000_010c;
  localparam logic [31:0] ADDR_CORE_CTRL2   = 32'h4000_0200;
  localparam logic [31:0] ADDR_COEX_STATUS  = 32'h4000_0110;

  // Coexistence control fields
  localparam int RX_MODE_LSB     = 20;
  localparam int TX_MODE_LSB     = 16;
  localparam int WLAN_TX_MSK_LSB = 6;
  localparam int WLAN_RX_MSK_LSB = 4;
  localparam int SYNC_GEN_BIT    = 1;
  localparam int COEXISTENCE_ENABLE_BIT     = 0;
  localparam logic [1:0] WLAN_TX_MSK_RST = 2'h0;
  localparam logic [1:0] WLAN_RX_MSK_RST = 2'h1;

  // Indication mode codes
  localparam logic [1:0] MODE_EXCL_PWRUP = 2'h0;
  localparam logic [1:0] MODE_INCL_PWRUP = 2'h1;
  localparam logic [1:0] MODE_HIGH_PRIO  = 2'h2;

  // Priority timing fields
  localparam int RX_THR_LSB = 24;
  localparam int TX_THR_LSB = 16;
  localparam int HOLD_LSB   = 8;
  localparam int LEAD_LSB   = 0;
  localparam logic [31:0] PRIO_TIMING_RST = 32'h0000_0000;

  // Priority table resets, one nibble per message kind, lowest nibble first
  localparam logic [3:0] RST_CONNECT_REQUEST  = 4'hf;
  localparam logic [3:0] RST_LINK_CONTROL     = 4'he;
  localparam logic [3:0] RST_DATA_CHANNEL     = 4'hd;
  localparam logic [3:0] RST_INITIATING_SCAN  = 4'ha;
  localparam logic [3:0] RST_ACTIVE_SCAN      = 4'h9;
  localparam logic [3:0] RST_CONN_ADVERTISING = 4'h8;
  localparam logic [3:0] RST_NONCONN_ADV      = 4'h4;
  localparam logic [3:0] RST_PASSIVE_SCAN     = 4'h3;
  localparam logic [3:0] RST_DEFAULT          = 4'h3;
  localparam logic [31:0] PRIO_TABLE_A_RST = {RST_PASSIVE_SCAN, RST_NONCONN_ADV, RST_CONN_ADVERTISING,
                                              RST_ACTIVE_SCAN, RST_INITIATING_SCAN, RST_DATA_CHANNEL,
                                              RST_LINK_CONTROL, RST_CONNECT_REQUEST};
  localparam int DEFAULT_LSB = 28;

  // Core control 2 and status fields
  localparam int SRC_SEL_BIT     = 17;
  localparam int STAT_TX_BIT     = 0;
  localparam int STAT_RX_BIT     = 1;
  localparam int STAT_PTI_LSB    = 4;
  localparam int TABLE_ENTRIES   = 8;

  // Timer states
  typedef enum logic [2:0] {
    TMR_IDLE = 3'b001,
    TMR_LEAD = 3'b010,
    TMR_HOLD = 3'b100
  } rcx_tmr_e;

endpackage : rcx_pkg

/* design/rcx_timer_if.sv */
// Interface between the priority control and one lead/hold timer.
// Assumes both ends run on the same master clock.
`timescale 1ns/1ps
interface rcx_timer_if;
  logic       en;
  logic       armed;
  logic       high;
  logic [6:0] leadUs;
  logic [6:0] holdUs;
  logic       prio;

  modport ctrl  (output en, armed, high, leadUs, holdUs, input prio);
  modport timer (input en, armed, high, leadUs, holdUs, output prio);
endinterface : rcx_timer_if

/* design/rcx_prio_timer.sv */
// Lead delay and hold timer for one direction of the priority indication.
// Assumes the control end keeps its inputs synchronous to mclk.
`timescale 1ns/1ps
module rcx_prio_timer (
  input  wire logic     mclk,
  input  wire logic     arst_n,
  rcx_timer_if.timer    tif
);

  rcx_pkg::rcx_tmr_e state;
  rcx_pkg::rcx_tmr_e next_state;
  logic              enPrev;
  logic [5:0]        cycCnt;
  logic [6:0]        usCnt;
  logic              usTick;
  logic              enRise;

  assign usTick = (cycCnt == rcx_pkg::US_LAST);
  assign enRise = tif.en && !enPrev;
  assign tif.prio = (state == rcx_pkg::TMR_HOLD);

  always_comb begin
    next_state = state;
    case (state)
      rcx_pkg::TMR_IDLE: begin
        if (enRise && tif.armed && tif.high) begin
          next_state = (tif.leadUs == 7'h00) ? rcx_pkg::TMR_HOLD : rcx_pkg::TMR_LEAD;
        end
      end
      rcx_pkg::TMR_LEAD: begin
        if (!tif.armed || !tif.en) begin
          next_state = rcx_pkg::TMR_IDLE;
        end else if (usTick && usCnt == tif.leadUs - 7'h01) begin
          next_state = rcx_pkg::TMR_HOLD;
        end
      end
      rcx_pkg::TMR_HOLD: begin
        if (!tif.armed) begin
          next_state = rcx_pkg::TMR_IDLE;
        end else if (tif.holdUs == 7'h00) begin
          if (!tif.en) begin
            next_state = rcx_pkg::TMR_IDLE;
          end
        end else if (usTick && usCnt == tif.holdUs - 7'h01) begin
          next_state = rcx_pkg::TMR_IDLE;
        end
      end
      default: next_state = rcx_pkg::TMR_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state  <= rcx_pkg::TMR_IDLE;
      enPrev <= 1'b0;
    end else begin
      state  <= next_state;
      enPrev <= tif.en;
    end
  end

  // Microsecond counting restarts on every state change
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cycCnt <= 6'h00;
      usCnt  <= 7'h00;
    end else if (next_state != state || state == rcx_pkg::TMR_IDLE) begin
      cycCnt <= 6'h00;
      usCnt  <= 7'h00;
    end else if (usTick) begin
      cycCnt <= 6'h00;
      usCnt  <= usCnt + 7'h01;
    end else begin
      cycCnt <= cycCnt + 6'h01;
    end
  end

endmodule : rcx_prio_timer

/* design/rcx_coex_prio.sv */
// Coexistence priority signalling: register file, message priority table, thresholds and line drive.
// Assumes a register master that follows the one-cycle strobe protocol and inputs synchronous to mclk.
`timescale 1ns/1ps
// Notes on behaviour
// - In Rx indicator mode, Rx priority high only when indication exceeds Rx threshold.
// - In Tx indicator mode, Tx priority high only when indication exceeds Tx threshold.
// - Indicator mode keeps priority asserted for the programmed hold time in microseconds.
// - A hold time of zero keeps priority until the matching enable falls.
// - Priority appears the programmed lead delay in microseconds after enable rises.
// - Passive scan priority in table A bits 31:28, resets to 3.
// - Non-connectable advertising priority in bits 27:24, resets to 4.
// - Connectable advertising priority in bits 23:20, resets to 8.
// - Active scan priority in bits 19:16, resets to 9.
// - Initiating scan priority in bits 15:12, resets to A.
// - Data channel priority in bits 11:8, resets to D.
// - Link control procedure priority in bits 7:4, resets to E.
// - Connection request response priority in bits 3:0, resets to F.
// - Default priority in table B bits 31:28, resets to 3, for other kinds.
// - Source select 0 uses table value, 1 uses the core's dynamic value.
// - Mode code 10 selects the high priority indicator with threshold and timing.
// - Coexistence lines driven only while the coexistence enable bit is set.
module rcx_coex_prio (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic [31:0] regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdata,
  input  wire logic        txEnable,
  input  wire logic        rxEnable,
  input  wire logic [3:0]  msgKind,
  input  wire logic [3:0]  dynPriority,
  output logic      [3:0]  priorityIndication,
  output logic             coexTx,
  output logic             coexRx,
  output logic             txPriorityHigh,
  output logic             rxPriorityHigh
);

  // Coexistence control fields
  logic [1:0] rxIndicationMode;
  logic [1:0] txIndicationMode;
  logic [1:0] wlanTxMask;
  logic [1:0] wlanRxMask;
  logic       syncGenEnable;
  logic       coexistenceEnable;

  // Timing, table and source select
  logic [31:0] coexPriorityTimingControl;
  logic [31:0] messagePriorityTableA;
  logic [3:0]  prioDefault;
  logic        prioSourceSelect;

  // Derived values
  logic [4:0] rxPriorityThreshold;
  logic [4:0] txPriorityThreshold;
  logic [6:0] priorityHoldTime;
  logic [6:0] priorityLeadDelay;
  logic [3:0] tablePriority;
  logic [3:0] next_priority;
  logic       txIndicator;
  logic       rxIndicator;
  logic       next_coexTx;
  logic       next_coexRx;
  logic [31:0] next_rdata;

  rcx_timer_if txTif ();
  rcx_timer_if rxTif ();

  function automatic logic [3:0] table_lookup(input logic [3:0]  kind,
                                              input logic [31:0] tableA,
                                              input logic [3:0]  dflt);
    logic [3:0] result;
    result = dflt;
    if (kind < 4'(rcx_pkg::TABLE_ENTRIES)) begin
      result = tableA[{kind[2:0], 2'b00} +: 4];
    end
    return result;
  endfunction : table_lookup

  function automatic logic exceeds(input logic [3:0] prio, input logic [4:0] thr);
    return {1'b0, prio} > thr;
  endfunction : exceeds

  assign rxPriorityThreshold = coexPriorityTimingControl[rcx_pkg::RX_THR_LSB +: 5];
  assign txPriorityThreshold = coexPriorityTimingControl[rcx_pkg::TX_THR_LSB +: 5];
  assign priorityHoldTime    = coexPriorityTimingControl[rcx_pkg::HOLD_LSB +: 7];
  assign priorityLeadDelay   = coexPriorityTimingControl[rcx_pkg::LEAD_LSB +: 7];

  assign txIndicator = (txIndicationMode == rcx_pkg::MODE_HIGH_PRIO);
  assign rxIndicator = (rxIndicationMode == rcx_pkg::MODE_HIGH_PRIO);

  // Coexistence control register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rxIndicationMode  <= rcx_pkg::MODE_EXCL_PWRUP;
      txIndicationMode  <= rcx_pkg::MODE_EXCL_PWRUP;
      wlanTxMask        <= rcx_pkg::WLAN_TX_MSK_RST;
      wlanRxMask        <= rcx_pkg::WLAN_RX_MSK_RST;
      syncGenEnable     <= 1'b0;
      coexistenceEnable <= 1'b0;
    end else if (regWrite && regAddr == rcx_pkg::ADDR_COEX_CTRL) begin
      rxIndicationMode  <= regWdata[rcx_pkg::RX_MODE_LSB +: 2];
      txIndicationMode  <= regWdata[rcx_pkg::TX_MODE_LSB +: 2];
      wlanTxMask        <= regWdata[rcx_pkg::WLAN_TX_MSK_LSB +: 2];
      wlanRxMask        <= regWdata[rcx_pkg::WLAN_RX_MSK_LSB +: 2];
      syncGenEnable     <= regWdata[rcx_pkg::SYNC_GEN_BIT];
      coexistenceEnable <= regWdata[rcx_pkg::COEXISTENCE_ENABLE_BIT];
    end
  end

  // Priority timing register, reserved bits kept at zero
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      coexPriorityTimingControl <= rcx_pkg::PRIO_TIMING_RST;
    end else if (regWrite && regAddr == rcx_pkg::ADDR_PRIO_TIMING) begin
      coexPriorityTimingControl <= '0;
      coexPriorityTimingControl[rcx_pkg::RX_THR_LSB +: 5] <= regWdata[rcx_pkg::RX_THR_LSB +: 5];
      coexPriorityTimingControl[rcx_pkg::TX_THR_LSB +: 5] <= regWdata[rcx_pkg::TX_THR_LSB +: 5];
      coexPriorityTimingControl[rcx_pkg::HOLD_LSB +: 7]   <= regWdata[rcx_pkg::HOLD_LSB +: 7];
      coexPriorityTimingControl[rcx_pkg::LEAD_LSB +: 7]   <= regWdata[rcx_pkg::LEAD_LSB +: 7];
    end
  end

  // Message priority table
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      messagePriorityTableA <= rcx_pkg::PRIO_TABLE_A_RST;
    end else if (regWrite && regAddr == rcx_pkg::ADDR_PRIO_TABLE_A) begin
      messagePriorityTableA <= regWdata;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prioDefault <= rcx_pkg::RST_DEFAULT;
    end else if (regWrite && regAddr == rcx_pkg::ADDR_PRIO_TABLE_B) begin
      prioDefault <= regWdata[rcx_pkg::DEFAULT_LSB +: 4];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prioSourceSelect <= 1'b0;
    end else if (regWrite && regAddr == rcx_pkg::ADDR_CORE_CTRL2) begin
      prioSourceSelect <= regWdata[rcx_pkg::SRC_SEL_BIT];
    end
  end

  // Priority indication selection
  always_comb begin
    tablePriority = table_lookup(msgKind, messagePriorityTableA, prioDefault);
    next_priority = prioSourceSelect ? dynPriority : tablePriority;
    if (!coexistenceEnable) begin
      next_priority = 4'h0;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      priorityIndication <= 4'h0;
    end else begin
      priorityIndication <= next_priority;
    end
  end

  // Timer hookup
  assign txTif.en     = txEnable;
  assign txTif.armed  = coexistenceEnable && txIndicator;
  assign txTif.high   = exceeds(priorityIndication, txPriorityThreshold);
  assign txTif.leadUs = priorityLeadDelay;
  assign txTif.holdUs = priorityHoldTime;

  assign rxTif.en     = rxEnable;
  assign rxTif.armed  = coexistenceEnable && rxIndicator;
  assign rxTif.high   = exceeds(priorityIndication, rxPriorityThreshold);
  assign rxTif.leadUs = priorityLeadDelay;
  assign rxTif.holdUs = priorityHoldTime;

  rcx_prio_timer txTimer (
    .mclk   (mclk),
    .arst_n (arst_n),
    .tif    (txTif)
  );

  rcx_prio_timer rxTimer (
    .mclk   (mclk),
    .arst_n (arst_n),
    .tif    (rxTif)
  );

  // Coexistence line drive
  always_comb begin
    next_coexTx = 1'b0;
    next_coexRx = 1'b0;
    if (coexistenceEnable) begin
      if (txIndicator) begin
        next_coexTx = txTif.prio;
      end else if (txIndicationMode == rcx_pkg::MODE_EXCL_PWRUP ||
                   txIndicationMode == rcx_pkg::MODE_INCL_PWRUP) begin
        next_coexTx = txEnable;
      end
      if (rxIndicator) begin
        next_coexRx = rxTif.prio;
      end else if (rxIndicationMode == rcx_pkg::MODE_EXCL_PWRUP ||
                   rxIndicationMode == rcx_pkg::MODE_INCL_PWRUP) begin
        next_coexRx = rxEnable;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      coexTx         <= 1'b0;
      coexRx         <= 1'b0;
      txPriorityHigh <= 1'b0;
      rxPriorityHigh <= 1'b0;
    end else begin
      coexTx         <= next_coexTx;
      coexRx         <= next_coexRx;
      txPriorityHigh <= coexistenceEnable && txIndicator && txTif.prio;
      rxPriorityHigh <= coexistenceEnable && rxIndicator && rxTif.prio;
    end
  end

  // Register read path
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (regAddr == rcx_pkg::ADDR_COEX_CTRL) begin
      next_rdata[rcx_pkg::RX_MODE_LSB +: 2]     = rxIndicationMode;
      next_rdata[rcx_pkg::TX_MODE_LSB +: 2]     = txIndicationMode;
      next_rdata[rcx_pkg::WLAN_TX_MSK_LSB +: 2] = wlanTxMask;
      next_rdata[rcx_pkg::WLAN_RX_MSK_LSB +: 2] = wlanRxMask;
      next_rdata[rcx_pkg::SYNC_GEN_BIT]         = syncGenEnable;
      next_rdata[rcx_pkg::COEXISTENCE_ENABLE_BIT]          = coexistenceEnable;
    end else if (regAddr == rcx_pkg::ADDR_PRIO_TIMING) begin
      next_rdata = coexPriorityTimingControl;
    end else if (regAddr == rcx_pkg::ADDR_PRIO_TABLE_A) begin
      next_rdata = messagePriorityTableA;
    end else if (regAddr == rcx_pkg::ADDR_PRIO_TABLE_B) begin
      next_rdata[rcx_pkg::DEFAULT_LSB +: 4] = prioDefault;
    end else if (regAddr == rcx_pkg::ADDR_CORE_CTRL2) begin
      next_rdata[rcx_pkg::SRC_SEL_BIT] = prioSourceSelect;
    end else if (regAddr == rcx_pkg::ADDR_COEX_STATUS) begin
      next_rdata[rcx_pkg::STAT_TX_BIT]       = txPriorityHigh;
      next_rdata[rcx_pkg::STAT_RX_BIT]       = rxPriorityHigh;
      next_rdata[rcx_pkg::STAT_PTI_LSB +: 4] = priorityIndication;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= 32'h0000_0000;
    end else if (regRead) begin
      regRdata <= next_rdata;
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end

endmodule : rcx_coex_prio

/* dv/rcx_coex_prio_monitor.sv */
// Checker for the coexistence priority block, attached to its top module by bind.
// Assumes a 50 MHz mclk and the register map held in rcx_pkg.
`timescale 1ns/1ps
module rcx_coex_prio_monitor (
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic [31:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [31:0] regRdata,
  input wire logic        txEnable,
  input wire logic        rxEnable,
  input wire logic [3:0]  msgKind,
  input wire logic [3:0]  dynPriority,
  input wire logic [3:0]  priorityIndication,
  input wire logic        coexTx,
  input wire logic        coexRx,
  input wire logic        txPriorityHigh,
  input wire logic        rxPriorityHigh
);
  logic        ctrlEn;
  logic [1:0]  txMode;
  logic        srcSel;
  logic [6:0]  holdUs;
  logic [6:0]  leadUs;
  logic [15:0] hiCnt;
  logic [15:0] enCnt;
  logic [15:0] usCyc;
  assign usCyc = 16'(rcx_pkg::CYC_PER_US);
  // Shadow copies of the fields that shape the Tx indication
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrlEn <= 1'b0;
      txMode <= 2'h0;
      srcSel <= 1'b0;
      holdUs <= 7'h0;
      leadUs <= 7'h0;
    end else if (regWrite) begin
      if (regAddr == rcx_pkg::ADDR_COEX_CTRL) begin
        ctrlEn <= regWdata[rcx_pkg::COEXISTENCE_ENABLE_BIT];
        txMode <= regWdata[rcx_pkg::TX_MODE_LSB +: 2];
      end
      if (regAddr == rcx_pkg::ADDR_CORE_CTRL2) begin
        srcSel <= regWdata[rcx_pkg::SRC_SEL_BIT];
      end
      if (regAddr == rcx_pkg::ADDR_PRIO_TIMING) begin
        holdUs <= regWdata[rcx_pkg::HOLD_LSB +: 7];
        leadUs <= regWdata[rcx_pkg::LEAD_LSB +: 7];
      end
    end
  end
  // Run lengths of the Tx high flag and of the Tx enable
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hiCnt <= 16'h0;
      enCnt <= 16'h0;
    end else begin
      hiCnt <= txPriorityHigh ? hiCnt + 16'h1 : 16'h0;
      enCnt <= txEnable ? enCnt + 16'h1 : 16'h0;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  rdata_idle_a: assert property (
    !$past(regRead) |-> regRdata == 32'h0) else $error("read data not zero outside a read answer");
  tx_line_a: assert property (
    txPriorityHigh |-> coexTx) else $error("tx high flag without tx line");
  rx_line_a: assert property (
    rxPriorityHigh |-> coexRx) else $error("rx high flag without rx line");
  disable_quiet_a: assert property (
    (!ctrlEn) [*3] |-> !coexTx && !coexRx && priorityIndication == 4'h0)
    else $error("coexistence outputs active while disabled");
  mode_low_a: assert property (
    (txMode != rcx_pkg::MODE_HIGH_PRIO) [*3] |-> !txPriorityHigh) else $error("tx high outside indicator mode");
  hold_len_a: assert property (
    $fell(txPriorityHigh) && ctrlEn && txMode == rcx_pkg::MODE_HIGH_PRIO && holdUs != 7'h0
    |-> hiCnt == usCyc * {9'h0, holdUs}) else $error("tx hold length wrong");
  hold_zero_a: assert property (
    txPriorityHigh && txEnable && ctrlEn && txMode == rcx_pkg::MODE_HIGH_PRIO && holdUs == 7'h0 && !regWrite
    |=> txPriorityHigh) else $error("tx priority dropped while enable high");
  lead_time_a: assert property (
    $rose(txPriorityHigh) |-> enCnt == 16'h2 + usCyc * {9'h0, leadUs}) else $error("tx lead delay wrong");
  src_dyn_a: assert property (
    ctrlEn && srcSel |=> priorityIndication == $past(dynPriority)) else $error("dynamic priority not passed");
endmodule : rcx_coex_prio_monitor

bind rcx_coex_prio rcx_coex_prio_monitor u_rcx_coex_prio_monitor (.mclk(mclk), .arst_n(arst_n),
  .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
  .txEnable(txEnable), .rxEnable(rxEnable), .msgKind(msgKind), .dynPriority(dynPriority),
  .priorityIndication(priorityIndication), .coexTx(coexTx), .coexRx(coexRx),
  .txPriorityHigh(txPriorityHigh), .rxPriorityHigh(rxPriorityHigh));

/* dv/rcx_arbiter_model.sv */
// Arbiter side model: watches the Tx and Rx lines and keeps the length of the last window of each.
// Assumes the lines are synchronous to mclk.
`timescale 1ns/1ps
module rcx_arbiter_model (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        coexTx,
  input  wire logic        coexRx,
  output logic      [15:0] lastTxLen,
  output logic      [15:0] lastRxLen
);
  logic [15:0] txRun;
  logic [15:0] rxRun;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      txRun     <= 16'h0;
      rxRun     <= 16'h0;
      lastTxLen <= 16'h0;
      lastRxLen <= 16'h0;
    end else begin
      txRun <= coexTx ? txRun + 16'h1 : 16'h0;
      rxRun <= coexRx ? rxRun + 16'h1 : 16'h0;
      if (!coexTx && txRun != 16'h0) lastTxLen <= txRun;
      if (!coexRx && rxRun != 16'h0) lastRxLen <= rxRun;
    end
  end
endmodule : rcx_arbiter_model

/* dv/rcx_coex_prio_test.sv */
// Self-checking bench for the coexistence priority block with an arbiter model on its lines.
// Assumes the design files and rcx_pkg are compiled first.
`timescale 1ns/1ps
module rcx_coex_prio_test;
  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  logic [31:0] regAddr = 32'h0;
  logic [31:0] regWdata = 32'h0;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic        txEnable = 1'b0;
  logic        rxEnable = 1'b0;
  logic [3:0]  msgKind = 4'h0;
  logic [3:0]  dynPriority = 4'h9;
  logic [31:0] regRdata;
  logic [3:0]  priorityIndication;
  logic        coexTx;
  logic        coexRx;
  logic        txPriorityHigh;
  logic        rxPriorityHigh;
  logic [15:0] lastTxLen;
  logic [15:0] lastRxLen;
  int          mismatches = 0;
  int          nChecks = 0;
  int          cycles = 0;

  rcx_coex_prio u_rcx_coex_prio (.mclk(mclk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .txEnable(txEnable), .rxEnable(rxEnable),
    .msgKind(msgKind), .dynPriority(dynPriority), .priorityIndication(priorityIndication), .coexTx(coexTx),
    .coexRx(coexRx), .txPriorityHigh(txPriorityHigh), .rxPriorityHigh(rxPriorityHigh));
  rcx_arbiter_model u_rcx_arbiter_model (.mclk(mclk), .arst_n(arst_n), .coexTx(coexTx), .coexRx(coexRx),
    .lastTxLen(lastTxLen), .lastRxLen(lastRxLen));

  always #10 mclk = ~mclk;

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", nChecks, mismatches);
    if (mismatches == 0 && nChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge mclk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRead <= 1'b0;
    @(negedge mclk);
    d = regRdata;
  endtask : rd

  function automatic logic [31:0] tim(input logic [4:0] rx, input logic [4:0] tx, input logic [6:0] h,
                                      input logic [6:0] l);
    return {3'h0, rx, 3'h0, tx, 1'h0, h, 1'h0, l};
  endfunction : tim

  // Pulses one enable for on cycles and counts samples with that direction's high flag
  task automatic burst(input bit rx, input int on, input int w, output int n, output int first);
    n = 0;
    first = -1;
    for (int i = 0; i < w; i++) begin
      @(posedge mclk);
      if (i == 0 || i == on) begin
        if (rx) rxEnable <= (i == 0);
        else txEnable <= (i == 0);
      end
      @(negedge mclk);
      if ((rx ? rxPriorityHigh : txPriorityHigh) === 1'b1) begin
        n++;
        if (first < 0) first = i;
      end
    end
  endtask : burst

  task automatic test_reset();
    logic [31:0] d;
    rd(rcx_pkg::ADDR_PRIO_TIMING, d);
    chk(d, 32'h0);
    rd(rcx_pkg::ADDR_PRIO_TABLE_A, d);
    chk(d, 32'h3489adef);
    rd(rcx_pkg::ADDR_PRIO_TABLE_B, d);
    chk(d, 32'h3000_0000);
    rd(rcx_pkg::ADDR_CORE_CTRL2, d);
    chk(d, 32'h0);
    rd(rcx_pkg::ADDR_COEX_CTRL, d);
    chk(d, 32'h0000_0010);
    chk({28'h0, coexTx, coexRx, txPriorityHigh, rxPriorityHigh}, 32'h0);
    $display("test reset done");
  endtask : test_reset

  task automatic test_table();
    logic [31:0] d;
    wr(rcx_pkg::ADDR_PRIO_TABLE_A, 32'h8765_4321);
    wr(rcx_pkg::ADDR_PRIO_TABLE_B, 32'hc000_0000);
    wr(32'h4000_0180, 32'hffff_ffff);
    rd(32'h4000_0180, d);
    chk(d, 32'h0);
    wr(rcx_pkg::ADDR_COEX_CTRL, 32'h1);
    for (int k = 0; k < 16; k++) begin
      @(posedge mclk);
      msgKind <= 4'(k);
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      chk({28'h0, priorityIndication}, (k < 8) ? 32'(k + 1) : 32'hc);
    end
    $display("test table done");
  endtask : test_table

  task automatic test_source();
    logic [31:0] d;
    wr(rcx_pkg::ADDR_CORE_CTRL2, 32'h0002_0000);
    @(posedge mclk);
    @(negedge mclk);
    chk({28'h0, priorityIndication}, 32'h9);
    rd(rcx_pkg::ADDR_COEX_STATUS, d);
    chk(d, 32'h0000_0090);
    @(posedge mclk);
    dynPriority <= 4'h6;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk({28'h0, priorityIndication}, 32'h6);
    @(posedge mclk);
    dynPriority <= 4'h9;
    wr(rcx_pkg::ADDR_COEX_CTRL, 32'h0);
    @(posedge mclk);
    txEnable <= 1'b1;
    repeat (3) @(negedge mclk);
    chk({27'h0, coexTx, priorityIndication}, 32'h0);
    @(posedge mclk);
    txEnable <= 1'b0;
    $display("test source done");
  endtask : test_source

  task automatic test_threshold();
    int n;
    int f;
    wr(rcx_pkg::ADDR_COEX_CTRL, 32'h0022_0001);
    for (int s = 0; s < 2; s++) begin
      wr(rcx_pkg::ADDR_PRIO_TIMING, s ? tim(5'h9, 5'h8, 7'h0, 7'h0) : tim(5'h8, 5'h9, 7'h0, 7'h0));
      burst(1'b0, 10, 20, n, f);
      chk(32'(f), s ? 32'h2 : 32'hffff_ffff);
      burst(1'b1, 10, 20, n, f);
      chk(32'(f), s ? 32'hffff_ffff : 32'h2);
    end
    $display("test threshold done");
  endtask : test_threshold

  task automatic test_timing();
    int n;
    int f;
    wr(rcx_pkg::ADDR_PRIO_TIMING, tim(5'h0, 5'h0, 7'h1, 7'h1));
    burst(1'b0, 60, 120, n, f);
    chk(32'(f), 32'd52);
    chk(32'(n), 32'd50);
    chk({16'h0, lastTxLen}, 32'd50);
    wr(rcx_pkg::ADDR_PRIO_TIMING, tim(5'h0, 5'h0, 7'h0, 7'h0));
    burst(1'b0, 30, 40, n, f);
    chk(32'(n), 32'd30);
    wr(rcx_pkg::ADDR_PRIO_TIMING, tim(5'h0, 5'h0, 7'h1, 7'h2));
    burst(1'b0, 40, 120, n, f);
    chk(32'(n), 32'h0);
    wr(rcx_pkg::ADDR_PRIO_TIMING, tim(5'h0, 5'h0, 7'h2, 7'h0));
    burst(1'b1, 5, 120, n, f);
    chk(32'(n), 32'd100);
    chk({16'h0, lastRxLen}, 32'd100);
    $display("test timing done");
  endtask : test_timing

  task automatic test_modes();
    int n;
    int f;
    for (int m = 0; m < 4; m++) begin
      if (m != 2) begin
        wr(rcx_pkg::ADDR_COEX_CTRL, {10'h0, 2'(m), 2'h0, 2'(m), 16'h1});
        burst(1'b0, 10, 20, n, f);
        chk(32'(n), 32'h0);
        burst(1'b1, 10, 20, n, f);
        chk(32'(n), 32'h0);
        chk({lastTxLen, lastRxLen}, {16'd10, 16'd10});
      end
    end
    $display("test modes done");
  endtask : test_modes

  initial begin
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    test_reset();
    test_table();
    test_source();
    test_threshold();
    test_timing();
    test_modes();
    stop_test();
  end
endmodule : rcx_coex_prio_test
